// >>> hdl/bex_top.sv
// bridge excitation drive and shared port pin control, with an apb register slave
//
// Overview of operation
// [R1] port select bit picks analog or digital pins
// [R2] positive shared pin follows port bit one
// [R3] negative shared pin follows port bit zero
// [R4] phase high is normal, low is reversed
// [R5] phase stays high unless alternating and chopping
// [R6] inverted phase toggles in anti-phase
// [R7] inverted phase stays low unless both enabled
// [R8] both low exactly one cycle per toggle
// [R9] reset returns all registers to power-on values
// [R10] drive outputs change only on clock edges (here the asynchronous reset also sets them)
//
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "bex_defines.svh"

module bex_top #(
  parameter int HALF_W = 16                         // width of the half-period count
) (
  // clock, reset and clock enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // bridge excitation drive
  output logic             bridge_drive_phase,
  output logic             bridge_drive_phase_n,
  // shared secondary-input pins, digital side
  output logic             secondary_pos_or_port_one_pin_out,
  output logic             secondary_pos_or_port_one_pin_oe_n,
  output logic             secondary_neg_or_port_zero_pin_out,
  output logic             secondary_neg_or_port_zero_pin_oe_n
);
  import bex_pkg::*;

  // ========================================================
  // declarations
  logic              port_output_select;            // 1: shared pins are digital outputs
  logic              port_bit_one;                  // level for the positive shared pin
  logic              port_bit_zero;                 // level for the negative shared pin
  logic              alternating_drive_mode;        // ac excitation requested
  logic              chopping_enable;               // chopping requested
  logic [HALF_W-1:0] half_period;                   // cycles spent in each excitation phase
  logic [HALF_W-1:0] phase_cnt;                     // cycles spent so far in this phase
  bex_phase_t        phase_state;                   // sequencer state
  bex_phase_t        next_phase_state;              // sequencer next state
  logic              chop_on;                       // both enables set
  logic              phase_done;                    // half period elapsed
  logic              acc;                           // apb access phase, taken this cycle
  logic              wr;                            // write taking effect
  logic              addr_ok;                       // address hits a register
  logic [31:0]       next_prdata;                   // read mux
  logic              rd_ld;                         // read data loaded for this transfer

  // ========================================================
  // bus handshake
  // a frozen block must not take an access, so ready follows the enable;
  // a read also waits until its data flip-flop has been loaded
  assign pready = ce & (pwrite | rd_ld);
  assign acc    = psel & penable & ce;
  assign wr     = acc & pwrite;

  // address decode for the error answer; the read mux decodes paddr in its own case
  function automatic logic bex_hit(input logic [11:0] a);
    bex_hit = (a == `BEX_ADDR_CTRL) || (a == `BEX_ADDR_HALF) || (a == `BEX_ADDR_STATUS);
  endfunction

  assign addr_ok = bex_hit(paddr);
  assign pslverr = psel & penable & ~addr_ok;

  // ========================================================
  // control register
  // all mode bits come back to power-on values under reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin                             // [R9]
      port_output_select     <= 1'b0;
      port_bit_zero          <= 1'b0;
      port_bit_one           <= 1'b0;
      alternating_drive_mode <= 1'b0;
      chopping_enable        <= 1'b0;
    end else if (wr && paddr == `BEX_ADDR_CTRL) begin
      port_output_select     <= pwdata[`BEX_CTRL_PORT_SEL];
      port_bit_zero          <= pwdata[`BEX_CTRL_BIT_ZERO];
      port_bit_one           <= pwdata[`BEX_CTRL_BIT_ONE];
      alternating_drive_mode <= pwdata[`BEX_CTRL_ALT_MODE];
      chopping_enable        <= pwdata[`BEX_CTRL_CHOP_EN];
    end
  end

  // ========================================================
  // half-period register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin                             // [R9]
      half_period <= HALF_W'(`BEX_HALF_RESET);
    end else if (wr && paddr == `BEX_ADDR_HALF) begin
      half_period <= pwdata[HALF_W-1:0];
    end
  end

  // ========================================================
  // read mux, loaded into prdata at the setup edge
  always_comb begin
    next_prdata = 32'h0000_0000;
    unique case (paddr)
      `BEX_ADDR_CTRL: begin
        next_prdata[`BEX_CTRL_PORT_SEL] = port_output_select;
        next_prdata[`BEX_CTRL_BIT_ZERO] = port_bit_zero;
        next_prdata[`BEX_CTRL_BIT_ONE]  = port_bit_one;
        next_prdata[`BEX_CTRL_ALT_MODE] = alternating_drive_mode;
        next_prdata[`BEX_CTRL_CHOP_EN]  = chopping_enable;
      end
      `BEX_ADDR_HALF: begin
        next_prdata[HALF_W-1:0] = half_period;
      end
      `BEX_ADDR_STATUS: begin
        next_prdata[`BEX_STAT_PHASE]   = bridge_drive_phase;
        next_prdata[`BEX_STAT_PHASE_N] = bridge_drive_phase_n;
        next_prdata[`BEX_STAT_DEAD]    = (phase_state == BEX_DEAD_TO_REV) ||
                                         (phase_state == BEX_DEAD_TO_NORM);
      end
      default: begin
        next_prdata = 32'h0000_0000;                // unmapped reads as zero
      end
    endcase
  end

  // read data is captured into a flip-flop at the setup edge, so it stands steady
  // through the whole access phase; a status bit may thus be one cycle old when taken
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      rd_ld  <= 1'b0;
    end else if (ce) begin
      if (psel && !pwrite && !rd_ld) begin
        // setup edge, or the first enabled edge if the setup edge was frozen
        prdata <= next_prdata;
        rd_ld  <= 1'b1;
      end else if (!psel || (penable && pready)) begin
        rd_ld  <= 1'b0;                             // transfer over, arm for the next one
      end
    end
  end

  // ========================================================
  // excitation sequencer
  assign chop_on    = alternating_drive_mode & chopping_enable;
  // a zero half period is taken as one cycle so the sequencer cannot stall
  assign phase_done = (half_period == '0) || (phase_cnt >= half_period - HALF_W'(1));

  // next state: each toggle passes through one dead state
  always_comb begin
    next_phase_state = phase_state;
    unique case (phase_state)
      BEX_NORMAL: begin
        if (chop_on && phase_done) begin
          next_phase_state = BEX_DEAD_TO_REV;       // [R8]
        end
      end
      BEX_DEAD_TO_REV: begin
        // disabled mid-toggle: go straight back to the steady high
        next_phase_state = chop_on ? BEX_REVERSED : BEX_NORMAL;
      end
      BEX_REVERSED: begin
        // leaving reversed, even on disable, still needs the dead cycle
        if (!chop_on || phase_done) begin
          next_phase_state = BEX_DEAD_TO_NORM;      // [R8]
        end
      end
      BEX_DEAD_TO_NORM: begin
        next_phase_state = BEX_NORMAL;
      end
    endcase
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin                             // [R9]
      phase_state <= BEX_NORMAL;
    end else if (ce) begin
      phase_state <= next_phase_state;
    end
  end

  // phase length counter, restarted on every state change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_cnt <= '0;
    end else if (ce) begin
      if (next_phase_state != phase_state || !chop_on) begin
        phase_cnt <= '0;
      end else if (!phase_done) begin
        phase_cnt <= phase_cnt + HALF_W'(1);
      end
    end
  end

  // drive outputs from flip-flops, so they only move on clock edges or on the asynchronous reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bridge_drive_phase   <= 1'b1;                 // [R5]
      bridge_drive_phase_n <= 1'b0;                 // [R7]
    end else if (ce) begin                          // [R10]
      // high only in normal; low in reversed and dead states
      bridge_drive_phase   <= (next_phase_state == BEX_NORMAL);   // [R4] [R5]
      // complement, except both low through the dead state
      bridge_drive_phase_n <= (next_phase_state == BEX_REVERSED); // [R6] [R7] [R8]
    end
  end

  // ========================================================
  // shared pins: driven only when digital output use is selected
  // while released the pins belong to the analog input pair
  assign secondary_pos_or_port_one_pin_out    = port_bit_one;         // [R2]
  assign secondary_pos_or_port_one_pin_oe_n   = ~port_output_select;  // [R1]
  assign secondary_neg_or_port_zero_pin_out   = port_bit_zero;        // [R3]
  assign secondary_neg_or_port_zero_pin_oe_n  = ~port_output_select;  // [R1]

endmodule

`default_nettype wire

// >>> hdl/bex_defines.svh
// register offsets, field positions, reset values and timing counts of the bridge excitation block
`ifndef BEX_DEFINES_SVH
`define BEX_DEFINES_SVH

// ==========================================================
// register byte offsets (12-bit apb address)
`define BEX_ADDR_CTRL        12'h000
`define BEX_ADDR_HALF        12'h004
`define BEX_ADDR_STATUS      12'h008

// ==========================================================
// control register field positions
`define BEX_CTRL_PORT_SEL    0
`define BEX_CTRL_BIT_ZERO    1
`define BEX_CTRL_BIT_ONE     2
`define BEX_CTRL_ALT_MODE    3
`define BEX_CTRL_CHOP_EN     4

// ==========================================================
// status register field positions
`define BEX_STAT_PHASE       0
`define BEX_STAT_PHASE_N     1
`define BEX_STAT_DEAD        2

// ==========================================================
// reset values
`define BEX_CTRL_RESET       5'h00
`define BEX_HALF_RESET       16'h0100

// ==========================================================
// timing: dead interval between the two drive outputs, in master clock cycles
`define BEX_DEAD_CYCLES      1

`endif

// >>> hdl/bex_pkg.sv
// types shared by the bridge excitation block
package bex_pkg;

  // ========================================================
  // excitation phase sequencer states
  typedef enum logic [1:0] {
    BEX_NORMAL,
    BEX_DEAD_TO_REV,
    BEX_REVERSED,
    BEX_DEAD_TO_NORM
  } bex_phase_t;

endpackage

// >>> dv/bex_top_monitor.sv
// checker of the bridge drive outputs and shared port pins
`timescale 1ns/1ps
`default_nettype none
module bex_top_monitor (
  // clock, reset and apb
  input wire logic        pclk, presetn, ce, psel, penable, pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // drive outputs and pins
  input wire logic        bridge_drive_phase, bridge_drive_phase_n,
  input wire logic        secondary_pos_or_port_one_pin_out, secondary_pos_or_port_one_pin_oe_n,
  input wire logic        secondary_neg_or_port_zero_pin_out, secondary_neg_or_port_zero_pin_oe_n
);
  // ========================================================
  // helper logic
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic run;                                         // shadow of alternating and chopping bits
  wire  wr0 = psel & penable & pwrite & ce & (paddr == 12'h000);
  // shadow follows control writes so the idle rules need no peek inside
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) run <= 1'b0;
    else if (wr0) run <= pwdata[3] & pwdata[4];
  // ========================================================
  // properties
  property p_sel;  wr0 |=> secondary_pos_or_port_one_pin_oe_n == !$past(pwdata[0])
                        && secondary_neg_or_port_zero_pin_oe_n == !$past(pwdata[0]); endproperty
  property p_one;  wr0 |=> secondary_pos_or_port_one_pin_out == $past(pwdata[2]); endproperty
  property p_zero; wr0 |=> secondary_neg_or_port_zero_pin_out == $past(pwdata[1]); endproperty
  // three cycles cover the one dead cycle left after a late disable
  property p_high; !run [*3] |-> bridge_drive_phase; endproperty
  property p_low;  !run [*3] |-> !bridge_drive_phase_n; endproperty
  property p_excl; !(bridge_drive_phase && bridge_drive_phase_n); endproperty
  property p_dead; $fell(bridge_drive_phase) |-> !bridge_drive_phase_n; endproperty
  property p_rev;  $rose(bridge_drive_phase_n) |-> $past(bridge_drive_phase, 2); endproperty
  property p_rst;  $rose(presetn) |-> bridge_drive_phase && !bridge_drive_phase_n
    && secondary_pos_or_port_one_pin_oe_n && secondary_neg_or_port_zero_pin_oe_n; endproperty
  a_sel:  assert property (p_sel)  else $error("port enables wrong after control write");
  a_one:  assert property (p_one)  else $error("positive pin level wrong");
  a_zero: assert property (p_zero) else $error("negative pin level wrong");
  a_high: assert property (p_high) else $error("phase not high while idle");
  a_low:  assert property (p_low)  else $error("inverted phase not low while idle");
  a_excl: assert property (p_excl) else $error("both drive outputs high");
  a_dead: assert property (p_dead) else $error("no dead cycle before reversal");
  a_rev:  assert property (p_rev)  else $error("dead interval not one cycle");
  a_rst:  assert property (p_rst)  else $error("outputs not at reset values");
  c_rev:  cover property ($rose(bridge_drive_phase_n));
  c_norm: cover property ($rose(bridge_drive_phase));
  c_pins: cover property (wr0 && pwdata[0]);
endmodule
bind bex_top bex_top_monitor i_bex_top_monitor (.*);
`default_nettype wire

// >>> dv/bex_bridge_switch.sv
// far-side model of the bridge reversing switches
`timescale 1ns/1ps
`default_nettype none
module bex_bridge_switch (
  input  wire logic pclk,
  input  wire logic drive_normal,   // closes the normal switch pair
  input  wire logic drive_reverse,  // closes the reversing switch pair
  output logic      shorted         // sticky: both pairs closed at once
);
  // both pairs conducting would short the excitation supply
  initial shorted = 1'b0;
  always @(posedge pclk) if (drive_normal && drive_reverse) shorted <= 1'b1;
endmodule
`default_nettype wire

// >>> dv/bex_top_tb.sv
// self-checking bench for the bridge excitation block
`timescale 1ns/1ps
`default_nettype none
module bex_top_tb;
  // ========================================================
  // signals
  logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, shorted, err_rsp;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic bridge_drive_phase, bridge_drive_phase_n, secondary_pos_or_port_one_pin_out;
  logic secondary_pos_or_port_one_pin_oe_n, secondary_neg_or_port_zero_pin_out, secondary_neg_or_port_zero_pin_oe_n;
  int errors = 0, n_tests = 0, h, k, e;
  int hv[2] = '{0, 3};                               // zero half count runs as one
  bex_top i_bex_top (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .bridge_drive_phase(bridge_drive_phase), .bridge_drive_phase_n(bridge_drive_phase_n),
    .secondary_pos_or_port_one_pin_out(secondary_pos_or_port_one_pin_out),
    .secondary_pos_or_port_one_pin_oe_n(secondary_pos_or_port_one_pin_oe_n),
    .secondary_neg_or_port_zero_pin_out(secondary_neg_or_port_zero_pin_out),
    .secondary_neg_or_port_zero_pin_oe_n(secondary_neg_or_port_zero_pin_oe_n));
  bex_bridge_switch i_bex_bridge_switch (.pclk(pclk), .drive_normal(bridge_drive_phase),
    .drive_reverse(bridge_drive_phase_n), .shorted(shorted));
  always #5 pclk = ~pclk;
  // ========================================================
  // tasks
  function logic [31:0] outs();
    return {26'h0, bridge_drive_phase, bridge_drive_phase_n, secondary_pos_or_port_one_pin_out,
      secondary_pos_or_port_one_pin_oe_n, secondary_neg_or_port_zero_pin_out, secondary_neg_or_port_zero_pin_oe_n};
  endfunction
  task chk(input string name, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task finish_test;
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // one apb transfer; request held until pready is seen
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk) penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin @(posedge pclk); n++; end
    if (pready !== 1'b1) begin errors++; finish_test; end
    rd = prdata; err_rsp = pslverr;
    psel <= 0; penable <= 0;
  endtask
  // ========================================================
  // tests
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1;
    apb(0, 12'h000, 0); chk("ctrl", rd, 32'h0);
    apb(0, 12'h004, 0); chk("half", rd, 32'h100);
    apb(0, 12'h008, 0); chk("status", rd, 32'h1);
    chk("pins", outs(), 32'h25);
    apb(0, 12'h00C, 0); chk("unmapped", 32'(err_rsp), 32'h1);
    $display("test reset done");
    for (k = 0; k < 8; k++) begin
      apb(1, 12'h000, 32'(k)); @(posedge pclk); #1;
      chk("pins", outs(), {26'h0, 2'b10, k[2], !k[0], k[1], !k[0]});
    end
    $display("test pins done");
    for (h = 0; h < 2; h++) begin
      apb(1, 12'h000, 0); apb(1, 12'h004, 32'(hv[h])); apb(1, 12'h000, 32'h18);
      e = (hv[h] == 0) ? 1 : hv[h];
      k = 0;
      do begin @(posedge pclk); #1; k++; end while (bridge_drive_phase !== 1'b0 && k < 600);
      if (bridge_drive_phase !== 1'b0) begin errors++; finish_test; end
      // index zero is the dead cycle entering reversal
      for (k = 0; k <= 2*e+2; k++) begin
        chk("drive", {bridge_drive_phase, bridge_drive_phase_n}, {k > e+1 && k <= 2*e+1, k >= 1 && k <= e});
        @(posedge pclk); #1;
      end
    end
    for (h = 0; h < 2; h++) begin
      apb(1, 12'h000, 32'h18); repeat (5) @(posedge pclk);
      apb(1, 12'h000, h ? 32'h10 : 32'h08); repeat (3) @(posedge pclk);
      for (k = 0; k < 6; k++) begin
        @(posedge pclk); #1;
        chk("idle", {bridge_drive_phase, bridge_drive_phase_n}, 2'b10);
      end
    end
    $display("test chop done");
    // a low enable holds the sequencer, so the normal phase stretches by the frozen edges
    apb(1, 12'h004, 32'd20); apb(1, 12'h000, 32'h18); repeat (5) @(posedge pclk);
    ce <= 0;
    for (k = 0; k < 9; k++) begin
      @(posedge pclk); #1;
      chk("frozen ready", 32'(pready), 32'h0);
      chk("frozen drive", {bridge_drive_phase, bridge_drive_phase_n}, 2'b10);
    end
    @(posedge pclk) ce <= 1;
    k = 0;
    do begin @(posedge pclk); #1; k++; end while (bridge_drive_phase !== 1'b0 && k < 100);
    chk("frozen length", k, 20 - 5);
    apb(1, 12'h000, 0);
    $display("test freeze done");
    apb(1, 12'h000, 32'h1D); repeat (7) @(posedge pclk);
    presetn <= 0; @(posedge pclk); #1;
    chk("reset pins", outs(), 32'h25);
    repeat (2) @(posedge pclk);
    presetn <= 1;
    apb(0, 12'h000, 0); chk("ctrl", rd, 32'h0);
    apb(0, 12'h004, 0); chk("half", rd, 32'h100);
    chk("short", 32'(shorted), 32'h0);
    $display("test reset mid-run done");
    finish_test;
  end
endmodule
`default_nettype wire
